// ===== src/pcfld_top.sv
// Link control, fast link down and indirect register access block
`timescale 1ns/1ps
module pcfld_top
  import pcfld_pkg::*;
#(
  parameter int WINDOW_CYCLES = FLD_WINDOW_CYC
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Management register port
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Extended register space
  output logic [15:0] ext_addr_o,
  output logic ext_wr_o,
  output logic ext_rd_o,
  output logic [15:0] ext_wdata_o,
  input wire logic [15:0] ext_rdata_i,
  // Second control register low bits
  input wire logic idle_err_en_i,
  input wire logic odd_nib_dis_i,
  input wire logic rmii_rxclk_sel_i,
  output logic rmii_ref_rx_clk_o,
  // Receive idle error detection
  input wire logic rx_idle_i,
  input wire logic rx_sym_err_i,
  output logic rx_idle_err_o,
  // Transmit nibble stream from the MAC
  input wire logic tx_en_i,
  input wire logic tx_er_i,
  output logic tx_en_o,
  output logic tx_er_o,
  // Line legs
  input wire logic tx_p_i,
  input wire logic tx_n_i,
  output logic twisted_pair_transmit_p_o,
  output logic twisted_pair_transmit_n_o,
  output logic twisted_pair_receive_p_o,
  output logic twisted_pair_receive_n_o,
  input wire logic twisted_pair_transmit_p_i,
  input wire logic twisted_pair_transmit_n_i,
  input wire logic twisted_pair_receive_p_i,
  input wire logic twisted_pair_receive_n_i,
  output logic rx_p_o,
  output logic rx_n_o,
  output logic pol_swap_o,
  output logic pair_swap_o,
  output logic port_mirror_o,
  // Fast link down sources
  input wire logic mii_rx_err_i,
  input wire logic mlt3_viol_i,
  input wire logic snr_low_i,
  input wire logic energy_lost_i,
  output logic link_drop_o
);
  logic [6:0] cr3_ff;
  logic [1:0] func_ff;
  logic [4:0] devad_ff;
  logic [15:0] ptr_ff;
  logic [15:0] nxt_ptr;
  logic [8:4] link_drop_cause_status_ff;
  logic [8:4] nxt_link_drop_cause_status;
  logic [3:0] cause;
  logic [2:0] trip;
  logic nib_odd_ff;
  logic stretch;
  logic ind_ok;
  logic data_acc;
  logic wr_acc;
  logic rd_acc;
  logic link_drop_cause_status_rd;
  logic [15:0] nxt_rdata;
  logic pol;
  logic swp;

  assign pol = cr3_ff[CR3_POL_SWAP_BIT];
  assign swp = cr3_ff[CR3_PAIR_SWAP_BIT];
  assign wr_acc = ce_i && reg_wr_i;
  assign rd_acc = ce_i && reg_rd_i && !reg_wr_i;

  // Third control register; upper bits are not stored at all
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cr3_ff <= CR3_RESET;
    end else if (wr_acc && reg_addr_i == PHY_CONTROL_THREE_ADDR) begin
      cr3_ff <= reg_wdata_i[6:0];
    end
  end

  // Access control register: function and device address
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      func_ff <= ACC_FUNC_RESET;
      devad_ff <= ACC_DEVAD_RESET;
    end else if (wr_acc && reg_addr_i == INDIRECT_ACCESS_CONTROL_ADDR) begin
      func_ff <= reg_wdata_i[ACC_FUNC_MSB:ACC_FUNC_LSB];
      devad_ff <= reg_wdata_i[ACC_DEVAD_MSB:0];
    end
  end

  // Accesses with a foreign device address reach neither the pointer nor the extended space; reads return zero
  assign ind_ok = (devad_ff == DEVAD_EXTENDED);
  assign data_acc = ind_ok && (reg_addr_i == INDIRECT_ADDRESS_OR_DATA_ADDR);

  // Extended space strobes; only the data register reaches it
  assign ext_addr_o = ptr_ff;
  assign ext_wdata_o = reg_wdata_i;
  assign ext_wr_o = wr_acc && data_acc && func_ff != PCFLD_FN_ADDRESS;
  assign ext_rd_o = rd_acc && data_acc && func_ff != PCFLD_FN_ADDRESS;

  // Pointer update per function code; increment wraps at 16 bits
  always_comb begin
    nxt_ptr = ptr_ff;
    if (data_acc && (wr_acc || rd_acc)) begin
      case (pcfld_func_t'(func_ff))
        PCFLD_FN_ADDRESS: begin
          if (wr_acc) begin
            nxt_ptr = reg_wdata_i;
          end
        end
        PCFLD_FN_DATA: begin
          nxt_ptr = ptr_ff;
        end
        PCFLD_FN_DATA_INC_RW: begin
          nxt_ptr = ptr_ff + 16'h0001;
        end
        PCFLD_FN_DATA_INC_WR: begin
          if (wr_acc) begin
            nxt_ptr = ptr_ff + 16'h0001;
          end
        end
        default: begin
          nxt_ptr = ptr_ff;
        end
      endcase
    end
  end

  // Pointer register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_ff <= POINTER_RESET;
    end else if (ce_i) begin
      ptr_ff <= nxt_ptr;
    end
  end

  // Read data mux; unmapped indexes read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_addr_i)
      PHY_CONTROL_THREE_ADDR: begin
        nxt_rdata = {9'h000, cr3_ff};
      end
      INDIRECT_ACCESS_CONTROL_ADDR: begin
        nxt_rdata = {func_ff, 9'h000, devad_ff};
      end
      INDIRECT_ADDRESS_OR_DATA_ADDR: begin
        if (!ind_ok) begin
          nxt_rdata = 16'h0000;
        end else if (func_ff == PCFLD_FN_ADDRESS) begin
          nxt_rdata = ptr_ff;
        end else begin
          nxt_rdata = ext_rdata_i;
        end
      end
      LINK_DROP_CAUSE_STATUS_ADDR: begin
        nxt_rdata = {7'h00, link_drop_cause_status_ff, 4'h0};
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= rd_acc;
      if (rd_acc) begin
        reg_rdata_o <= nxt_rdata;
      end
    end
  end

  // Receive symbol errors during idle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_idle_err_o <= 1'b0;
    end else if (ce_i) begin
      rx_idle_err_o <= idle_err_en_i && rx_idle_i && rx_sym_err_i;
    end
  end

  // Nibble parity of the current frame, cleared while idle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nib_odd_ff <= 1'b0;
    end else if (ce_i) begin
      nib_odd_ff <= tx_en_i ? !nib_odd_ff : 1'b0;
    end
  end

  // First idle cycle after an odd frame gets the extra errored cycle
  assign stretch = !tx_en_i && nib_odd_ff && !odd_nib_dis_i;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_en_o <= 1'b0;
      tx_er_o <= 1'b0;
    end else if (ce_i) begin
      tx_en_o <= tx_en_i || stretch;
      tx_er_o <= (tx_en_i && tx_er_i) || stretch;
    end
  end

  // Receive data reference clock choice is a static steering level
  assign rmii_ref_rx_clk_o = rmii_rxclk_sel_i;

  // Line steering; registered so the pins never glitch on a swap change
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      twisted_pair_transmit_p_o <= 1'b0;
      twisted_pair_transmit_n_o <= 1'b0;
      twisted_pair_receive_p_o <= 1'b0;
      twisted_pair_receive_n_o <= 1'b0;
      rx_p_o <= 1'b0;
      rx_n_o <= 1'b0;
    end else if (ce_i) begin
      // Transmit legs go to the receive pair when swapped
      twisted_pair_transmit_p_o <= swp ? 1'b0 : (pol ? tx_n_i : tx_p_i);
      twisted_pair_transmit_n_o <= swp ? 1'b0 : (pol ? tx_p_i : tx_n_i);
      twisted_pair_receive_p_o <= swp ? (pol ? tx_n_i : tx_p_i) : 1'b0;
      twisted_pair_receive_n_o <= swp ? (pol ? tx_p_i : tx_n_i) : 1'b0;
      if (swp) begin
        rx_p_o <= pol ? twisted_pair_transmit_n_i : twisted_pair_transmit_p_i;
        rx_n_o <= pol ? twisted_pair_transmit_p_i : twisted_pair_transmit_n_i;
      end else begin
        rx_p_o <= pol ? twisted_pair_receive_n_i : twisted_pair_receive_p_i;
        rx_n_o <= pol ? twisted_pair_receive_p_i : twisted_pair_receive_n_i;
      end
    end
  end

  // Mode flags follow the register directly
  assign pol_swap_o = pol;
  assign pair_swap_o = swp;
  assign port_mirror_o = pol && swp;

  // Counted criteria, one windowed counter each
  pcfld_event_window #(.THRESHOLD(FLD_RXERR_COUNT), .WINDOW(WINDOW_CYCLES)) u_rxerr (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .enable_i(cr3_ff[CR3_FLD_RXERR_BIT]), .event_i(mii_rx_err_i),
    .trip_o(trip[2]));
  pcfld_event_window #(.THRESHOLD(FLD_MLT3_COUNT), .WINDOW(WINDOW_CYCLES)) u_mlt3 (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .enable_i(cr3_ff[CR3_FLD_MLT3_BIT]), .event_i(mlt3_viol_i),
    .trip_o(trip[1]));
  pcfld_event_window #(.THRESHOLD(FLD_SNR_COUNT), .WINDOW(WINDOW_CYCLES)) u_snr (
    .clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .enable_i(cr3_ff[CR3_FLD_SNR_BIT]), .event_i(snr_low_i),
    .trip_o(trip[0]));

  // Cause vector in status bit order: energy, snr, mlt3, rx errors
  assign cause[0] = cr3_ff[CR3_FLD_ENERGY_BIT] && energy_lost_i;
  assign cause[1] = trip[0];
  assign cause[2] = trip[1];
  assign cause[3] = trip[2];

  // Drop pulse is the OR of every enabled cause
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_drop_o <= 1'b0;
    end else if (ce_i) begin
      link_drop_o <= |cause;
    end
  end

  // Latched-high causes clear on read; a new cause in the read cycle wins
  assign link_drop_cause_status_rd = rd_acc && reg_addr_i == LINK_DROP_CAUSE_STATUS_ADDR;
  always_comb begin
    nxt_link_drop_cause_status = link_drop_cause_status_rd ? 5'h00 : link_drop_cause_status_ff;
    nxt_link_drop_cause_status[LINK_DROP_CAUSE_STATUS_RXERR_BIT:LINK_DROP_CAUSE_STATUS_ENERGY_BIT] =
      nxt_link_drop_cause_status[LINK_DROP_CAUSE_STATUS_RXERR_BIT:LINK_DROP_CAUSE_STATUS_ENERGY_BIT] | cause;
    nxt_link_drop_cause_status[LINK_DROP_CAUSE_STATUS_DESCR_BIT] = 1'b0; // Descrambler cause lives elsewhere
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_drop_cause_status_ff <= 5'h00;
    end else if (ce_i) begin
      link_drop_cause_status_ff <= nxt_link_drop_cause_status;
    end
  end

  a_cr3_high_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
    reg_rvalid_o && $past(reg_addr_i) == PHY_CONTROL_THREE_ADDR |-> reg_rdata_o[15:7] == 9'h000)
    else $error("reserved control bits not zero");
  a_mirror_both_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
    port_mirror_o == (pol_swap_o && pair_swap_o)) else $error("port mirror mismatch");
  a_stretch_error: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && !tx_en_i && nib_odd_ff && !odd_nib_dis_i |=> tx_en_o && tx_er_o)
    else $error("odd nibble end not stretched");
  a_idle_err_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && !idle_err_en_i |=> !rx_idle_err_o) else $error("idle error while disabled");
  a_ptr_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
    wr_acc && data_acc && func_ff == PCFLD_FN_ADDRESS |=> ptr_ff == $past(reg_wdata_i))
    else $error("pointer not loaded");
  a_ptr_inc_rw: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_acc || rd_acc) && data_acc && func_ff == PCFLD_FN_DATA_INC_RW
    |=> ptr_ff == $past(ptr_ff) + 16'h0001) else $error("pointer not incremented");
  a_ptr_rd_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_acc && func_ff == PCFLD_FN_DATA_INC_WR |=> $stable(ptr_ff))
    else $error("pointer moved on read");
  a_devad_ignore: assert property (@(posedge clock_i) disable iff (!rstn_i)
    devad_ff != DEVAD_EXTENDED |-> (!ext_wr_o && !ext_rd_o) ##1 $stable(ptr_ff))
    else $error("foreign device address acted on");
  a_energy_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && cr3_ff[CR3_FLD_ENERGY_BIT] && energy_lost_i
    |=> link_drop_o && link_drop_cause_status_ff[LINK_DROP_CAUSE_STATUS_ENERGY_BIT])
    else $error("energy loss did not drop link");
endmodule

// ===== src/pcfld_pkg.sv
// Constants shared by the link-control register block
package pcfld_pkg;
  // Register indexes on the management register port
  localparam logic [4:0] PHY_CONTROL_THREE_ADDR = 5'h0b;
  localparam logic [4:0] INDIRECT_ACCESS_CONTROL_ADDR = 5'h0d;
  localparam logic [4:0] INDIRECT_ADDRESS_OR_DATA_ADDR = 5'h0e;
  localparam logic [4:0] LINK_DROP_CAUSE_STATUS_ADDR = 5'h0f;
  // Third control register fields
  localparam int CR3_POL_SWAP_BIT = 6;
  localparam int CR3_PAIR_SWAP_BIT = 5;
  localparam int CR3_RSVD_BIT = 4;
  localparam int CR3_FLD_RXERR_BIT = 3;
  localparam int CR3_FLD_MLT3_BIT = 2;
  localparam int CR3_FLD_SNR_BIT = 1;
  localparam int CR3_FLD_ENERGY_BIT = 0;
  localparam logic [6:0] CR3_RESET = 7'h00;
  // Access control fields
  localparam int ACC_FUNC_MSB = 15;
  localparam int ACC_FUNC_LSB = 14;
  localparam int ACC_DEVAD_MSB = 4;
  localparam logic [1:0] ACC_FUNC_RESET = 2'h0;
  localparam logic [4:0] ACC_DEVAD_RESET = 5'h00;
  localparam logic [4:0] DEVAD_EXTENDED = 5'h1f;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  // Function codes of the access control register
  typedef enum logic [1:0] {
    PCFLD_FN_ADDRESS = 2'h0,
    PCFLD_FN_DATA = 2'h1,
    PCFLD_FN_DATA_INC_RW = 2'h2,
    PCFLD_FN_DATA_INC_WR = 2'h3
  } pcfld_func_t;
  // Link drop cause status field
  localparam int LINK_DROP_CAUSE_STATUS_ENERGY_BIT = 4;
  localparam int LINK_DROP_CAUSE_STATUS_SNR_BIT = 5;
  localparam int LINK_DROP_CAUSE_STATUS_MLT3_BIT = 6;
  localparam int LINK_DROP_CAUSE_STATUS_RXERR_BIT = 7;
  localparam int LINK_DROP_CAUSE_STATUS_DESCR_BIT = 8;
  // Second control register low bit defaults
  localparam logic IDLE_ERR_EN_RESET = 1'b1;
  // Fast link down timing and thresholds
  localparam int CLK_PERIOD_NS = 40;
  localparam int FLD_WINDOW_NS = 10000;
  localparam int FLD_WINDOW_CYC = (FLD_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  FLD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int FLD_RXERR_COUNT = 32;
  localparam int FLD_MLT3_COUNT = 20;
  localparam int FLD_SNR_COUNT = 20;
endpackage

// ===== src/pcfld_event_window.sv
// Counts events in fixed windows and pulses when a threshold is reached
`timescale 1ns/1ps
module pcfld_event_window #(
  parameter int THRESHOLD = 20,
  parameter int WINDOW = 250
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic event_i,
  output logic trip_o
);
  localparam int CW = $clog2(WINDOW + 1);
  localparam int EW = $clog2(THRESHOLD + 1);
  localparam logic [CW-1:0] WIN_LAST = CW'(WINDOW - 1);
  localparam logic [EW-1:0] THR_LAST = EW'(THRESHOLD - 1);

  logic [CW-1:0] win_ff;
  logic [EW-1:0] cnt_ff;
  logic hit;

  // Threshold reached by this event
  assign hit = enable_i && event_i && (cnt_ff == THR_LAST);

  // Window end or a hit restarts the count; a disabled criterion holds at zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_ff <= '0;
      cnt_ff <= '0;
      trip_o <= 1'b0;
    end else if (ce_i) begin
      trip_o <= hit;
      if (!enable_i || win_ff == WIN_LAST || hit) begin
        win_ff <= '0;
        cnt_ff <= '0;
      end else begin
        win_ff <= win_ff + 1'b1;
        if (event_i) begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  a_trip_after_hit: assert property (@(posedge clock_i) disable iff (!rstn_i)
    ce_i && hit |=> trip_o) else $error("threshold hit without trip");
endmodule

// ===== testbench/pcfld_ext_model.sv
// Behavioural extended register space that answers the indirect access port
`timescale 1ns/1ps
module pcfld_ext_model (
  input wire logic clock_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic ext_wr_i,
  input wire logic ext_rd_i,
  input wire logic [15:0] ext_wdata_i,
  output logic [15:0] ext_rdata_o
);
  logic [15:0] mem [int];
  logic [15:0] word;
  int wcount = 0;
  // Storage is reached only through the pointer port, never by direct index
  always @(posedge clock_i) begin
    if (ext_wr_i === 1'b1) begin
      mem[ext_addr_i] = ext_wdata_i;
      wcount++;
    end
  end
  // Outside a read the data lines show the inverse, so stale data never passes
  always @(ext_addr_i or ext_rd_i or wcount) begin
    word = mem.exists(ext_addr_i) ? mem[ext_addr_i] : 16'h0000;
    ext_rdata_o = (ext_rd_i === 1'b1) ? word : ~word;
  end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the link-control register block
`timescale 1ns/1ps
module tb_top;
  import pcfld_pkg::*;
  localparam int WIN = 100;
  logic clock_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, ext_addr_o, ext_wdata_o, ext_rdata_i;
  logic ide = 1, ond = 0, rsel = 0, ridle = 0, rserr = 0, txe = 0, tpt_p = 0, tpt_n = 1;
  logic tpr_p = 1, tpr_n = 0, energy = 0;
  logic [2:0] evs = 3'h0;
  logic reg_rvalid_o, ext_wr_o, ext_rd_o, rref, ierr, txe_o, txer_o, otp, otn, orp, orn;
  logic rxp, rxn, pol, pair, mir, link_drop_o;
  logic [1:0] fn = 2'h0;
  logic [4:0] dv = 5'h00;
  logic [15:0] bm [int];
  logic [15:0] v;
  int ptr = 0, failures = 0, n_checks = 0;
  int thr [3] = '{32, 20, 20};
  int ebit [3] = '{3, 2, 1};
  int sbit [3] = '{7, 6, 5};
  always #20 clock_i = ~clock_i;
  pcfld_top #(.WINDOW_CYCLES(WIN)) uut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .ext_addr_o(ext_addr_o), .ext_wr_o(ext_wr_o), .ext_rd_o(ext_rd_o),
    .ext_wdata_o(ext_wdata_o), .ext_rdata_i(ext_rdata_i), .idle_err_en_i(ide),
    .odd_nib_dis_i(ond), .rmii_rxclk_sel_i(rsel), .rmii_ref_rx_clk_o(rref),
    .rx_idle_i(ridle), .rx_sym_err_i(rserr), .rx_idle_err_o(ierr), .tx_en_i(txe),
    .tx_er_i(1'b0), .tx_en_o(txe_o), .tx_er_o(txer_o), .tx_p_i(1'b1), .tx_n_i(1'b0),
    .twisted_pair_transmit_p_o(otp), .twisted_pair_transmit_n_o(otn),
    .twisted_pair_receive_p_o(orp), .twisted_pair_receive_n_o(orn),
    .twisted_pair_transmit_p_i(tpt_p), .twisted_pair_transmit_n_i(tpt_n),
    .twisted_pair_receive_p_i(tpr_p), .twisted_pair_receive_n_i(tpr_n),
    .rx_p_o(rxp), .rx_n_o(rxn), .pol_swap_o(pol), .pair_swap_o(pair), .port_mirror_o(mir),
    .mii_rx_err_i(evs[0]), .mlt3_viol_i(evs[1]), .snr_low_i(evs[2]),
    .energy_lost_i(energy), .link_drop_o(link_drop_o));
  pcfld_ext_model ext (.clock_i(clock_i), .ext_addr_i(ext_addr_o), .ext_wr_i(ext_wr_o),
    .ext_rd_i(ext_rd_o), .ext_wdata_i(ext_wdata_o), .ext_rdata_o(ext_rdata_i));
  // Verdict and end of run, also reached when a bounded wait runs out
  task automatic complete_run();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read strobe is one cycle; the answer pulse is awaited under a bound
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int i;
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    for (i = 0; i < 4 && reg_rvalid_o !== 1'b1; i++) @(negedge clock_i);
    if (reg_rvalid_o !== 1'b1) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, reg_rvalid_o, 1'b1);
      complete_run();
    end
    d = reg_rdata_o;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic acc(input logic [1:0] f, input logic [4:0] d);
    wr(INDIRECT_ACCESS_CONTROL_ADDR, {f, 9'h000, d});
    fn = f;
    dv = d;
  endtask
  // Indirect write, mirrored into the bench copy of pointer and storage
  task automatic iw(input logic [15:0] d);
    wr(INDIRECT_ADDRESS_OR_DATA_ADDR, d);
    if (dv == DEVAD_EXTENDED && fn == 2'h0) ptr = d;
    else if (dv == DEVAD_EXTENDED) begin
      bm[ptr] = d;
      if (fn[1]) ptr = (ptr + 1) & 16'hffff;
    end
    @(negedge clock_i);
    chk(ext_addr_o, 16'(ptr));
  endtask
  task automatic ir();
    logic [15:0] d;
    rd(INDIRECT_ADDRESS_OR_DATA_ADDR, d);
    if (dv != DEVAD_EXTENDED) chk(d, 16'h0000);
    else chk(d, bm.exists(ptr) ? bm[ptr] : 16'h0000);
    if (dv == DEVAD_EXTENDED && fn == 2'h2) ptr = (ptr + 1) & 16'hffff;
    chk(ext_addr_o, 16'(ptr));
  endtask
  initial begin
    int k, i, n, c;
    logic seen;
    void'($urandom(66));
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    rdchk(PHY_CONTROL_THREE_ADDR, 16'h0000);
    rdchk(INDIRECT_ACCESS_CONTROL_ADDR, 16'h0000);
    rdchk(LINK_DROP_CAUSE_STATUS_ADDR, 16'h0000);
    rdchk(5'h1f, 16'h0000);
    $display("test reset values done");
    wr(PHY_CONTROL_THREE_ADDR, 16'hffff);
    rdchk(PHY_CONTROL_THREE_ADDR, 16'h007f);
    // Swap bits against the line legs; transmit legs drive 1/0
    for (k = 0; k < 4; k++) begin
      wr(PHY_CONTROL_THREE_ADDR, {9'h000, 2'(k), 5'h00});
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk({pol, pair, mir}, {k[1], k[0], k[1] & k[0]});
      chk({otp, otn, orp, orn}, k[0] ? {2'b00, ~k[1], k[1]} : {~k[1], k[1], 2'b00});
      chk({rxp, rxn}, {~(k[1] ^ k[0]), k[1] ^ k[0]});
    end
    $display("test swap done");
    acc(2'h0, 5'h00);
    iw(16'h0040);
    ir();
    acc(2'h0, DEVAD_EXTENDED);
    rdchk(INDIRECT_ACCESS_CONTROL_ADDR, 16'h001f);
    iw(16'h0040);
    acc(2'h1, DEVAD_EXTENDED);
    iw(16'($urandom()));
    ir();
    acc(2'h2, DEVAD_EXTENDED);
    repeat (3) iw(16'($urandom()));
    acc(2'h0, DEVAD_EXTENDED);
    iw(16'h0040);
    acc(2'h2, DEVAD_EXTENDED);
    repeat (5) ir();
    acc(2'h3, DEVAD_EXTENDED);
    rdchk(INDIRECT_ACCESS_CONTROL_ADDR, 16'hc01f);
    repeat (2) ir();
    iw(16'($urandom()));
    acc(2'h0, DEVAD_EXTENDED);
    iw(16'hffff);
    acc(2'h2, DEVAD_EXTENDED);
    iw(16'($urandom()));
    ir();
    $display("test indirect access done");
    for (k = 0; k < 4; k++) begin
      @(posedge clock_i);
      ide <= k[0];
      ridle <= k[1];
      rserr <= 1'($urandom()) | 1'b1;
      rsel <= k[0];
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk(ierr, k[0] & k[1]);
      chk(rref, k[0]);
    end
    $display("test idle error and clock select done");
    // Odd and even bursts, detection on and off
    for (k = 0; k < 3; k++) begin
      @(posedge clock_i);
      ond <= (k == 1);
      txe <= 1'b1;
      repeat (k == 2 ? 3 : 2) @(posedge clock_i);
      @(posedge clock_i);
      txe <= 1'b0;
      n = 0;
      repeat (5) begin
        @(negedge clock_i);
        n += (txe_o === 1'b1 && txer_o === 1'b1);
      end
      chk(16'(n), (k == 0) ? 16'h0001 : 16'h0000);
    end
    $display("test odd nibble done");
    // Counted causes: one short of threshold never trips, a longer run must
    for (c = 0; c < 3; c++) begin
      wr(PHY_CONTROL_THREE_ADDR, 16'h0001 << ebit[c]);
      n = 0;
      for (i = 0; i < thr[c] + 3; i++) begin
        @(posedge clock_i);
        evs <= (i < thr[c] - 1) ? (3'h1 << c) : 3'h0;
        @(negedge clock_i);
        n += (link_drop_o === 1'b1);
      end
      chk(16'(n), 16'h0000);
      seen = 1'b0;
      for (i = 0; i < 2 * thr[c] + 8 && seen !== 1'b1; i++) begin
        @(posedge clock_i);
        evs <= 3'h1 << c;
        @(negedge clock_i);
        seen = link_drop_o;
      end
      @(posedge clock_i);
      evs <= 3'h0;
      chk(seen, 1'b1);
      repeat (3) @(posedge clock_i);
      rdchk(LINK_DROP_CAUSE_STATUS_ADDR, 16'h0001 << sbit[c]);
      rdchk(LINK_DROP_CAUSE_STATUS_ADDR, 16'h0000);
    end
    $display("test counted link drop done");
    for (k = 0; k < 3; k++) begin
      wr(PHY_CONTROL_THREE_ADDR, (k == 0) ? 16'h0000 : (k == 1) ? 16'h0001 : 16'h000f);
      @(posedge clock_i);
      energy <= 1'b1;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk(link_drop_o, k != 0);
      @(posedge clock_i);
      energy <= 1'b0;
      repeat (3) @(posedge clock_i);
      rdchk(LINK_DROP_CAUSE_STATUS_ADDR, (k != 0) ? 16'h0010 : 16'h0000);
    end
    $display("test energy link drop done");
    complete_run();
  end
endmodule
